// File: logic/uart_irq_consts.svh
// register offsets, field positions, reset values and timing counts of the uart interrupt block
`ifndef UART_IRQ_CONSTS_SVH
`define UART_IRQ_CONSTS_SVH

// register offsets on the 8-bit register port
`define UIRQ_OFS_CTRL2 8'h00
`define UIRQ_OFS_STATUS 8'h01

// control two fields
`define UIRQ_C2_TX_EMPTY_IE 0
`define UIRQ_C2_TX_IDLE_IE 1
`define UIRQ_C2_RX_IE 2
`define UIRQ_C2_ADDR_EN 3
`define UIRQ_C2_WAKE_EN 4
`define UIRQ_C2_NINE_BIT 5
`define UIRQ_C2_UNIT_ON 6
`define UIRQ_C2_RECV_ON 7
`define UIRQ_C2_RESET 8'h00

// status fields
`define UIRQ_ST_TX_EMPTY 0
`define UIRQ_ST_TX_IDLE 1
`define UIRQ_ST_RX_AVAIL 2
`define UIRQ_ST_OVERRUN 3
`define UIRQ_ST_ADDR_BIT 4
`define UIRQ_ST_RUNNING 5
`define UIRQ_ST_SETTLING 6
`define UIRQ_FLAGS_RESET 4'h0

// settling time after a wake-up, in ns, and its count at the 200 MHz clock (rounded up)
`define UIRQ_CLK_MHZ 200
`define UIRQ_SETTLE_NS 1000
`define UIRQ_SETTLE_CYC ((`UIRQ_SETTLE_NS * `UIRQ_CLK_MHZ + 999) / 1000)

`endif

// File: logic/uart_irq_pkg.sv
// types shared by the uart interrupt block
`default_nettype none
package uart_irq_pkg;
  // power state of the serial source clock, gray along run -> off -> settle
  typedef enum logic [1:0]
  {
    ST_RUN = 2'b00,
    ST_OFF = 2'b01,
    ST_SETTLE = 2'b11
  } pwr_state_t;
endpackage
`default_nettype wire

// File: logic/sync2.sv
// two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module sync2
#(
  parameter logic RESET_VAL = 1'b0
)
(
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic async_i,
  output logic sync_o
);
  logic meta_reg;
  logic sync_reg;

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      meta_reg <= RESET_VAL;
      sync_reg <= RESET_VAL;
    end
    else
    begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;
endmodule
`default_nettype wire

// File: logic/uart_irq_addr_detect_wakeup.sv
// uart interrupt combiner with address detect qualification and receive-pin wake-up
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "uart_irq_consts.svh"
module uart_irq_addr_detect_wakeup
  import uart_irq_pkg::*;
#(
  parameter int SETTLE_CYC = `UIRQ_SETTLE_CYC
)
(
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic tx_empty_set_i,
  input wire logic tx_idle_set_i,
  input wire logic tx_load_i,
  input wire logic rx_avail_set_i,
  input wire logic rx_overrun_set_i,
  input wire logic [8:0] rx_word_i,
  input wire logic rx_data_read_i,
  input wire logic global_irq_enable_i,
  input wire logic serial_irq_enable_i,
  input wire logic clock_off_i,
  input wire logic rx_pin_i,
  output logic irq_n_o,
  output logic wake_o,
  output logic uart_run_o,
  output logic rx_ignore_o
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // address-qualifying bit of a received word
  function automatic logic qual_bit(input logic [8:0] word, input logic nine);
    qual_bit = nine ? word[8] : word[7];
  endfunction

  logic [7:0] uart_control_two;
  logic [7:0] ctrl_next;
  logic [3:0] uart_status_reg;
  logic [3:0] flags_next;
  logic addr_bit_reg;
  logic addr_bit_next;
  logic seq_armed_reg;
  logic seq_armed_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  pwr_state_t state_reg;
  pwr_state_t state_next;
  logic [15:0] settle_cnt_reg;
  logic [15:0] settle_cnt_next;
  logic wake_pend_reg;
  logic wake_pend_next;
  logic rx_prev_reg;
  logic req_prev_reg;
  logic irq_n_reg;
  logic irq_n_next;
  logic wake_reg;
  logic wake_next;
  logic run_reg;
  logic ignore_reg;
  logic clock_off_sync;
  logic rx_pin_sync;
  logic rx_fall;
  logic wake_arm;
  logic rx_data_src;
  logic addr_src;
  logic tx_src;
  logic wake_due;
  logic irq_req;

  wire logic tx_empty_ie = uart_control_two[`UIRQ_C2_TX_EMPTY_IE];
  wire logic tx_idle_ie = uart_control_two[`UIRQ_C2_TX_IDLE_IE];
  wire logic rx_irq_enable = uart_control_two[`UIRQ_C2_RX_IE];
  wire logic addr_detect_enable = uart_control_two[`UIRQ_C2_ADDR_EN];
  wire logic wake_enable = uart_control_two[`UIRQ_C2_WAKE_EN];
  wire logic nine_bit_select = uart_control_two[`UIRQ_C2_NINE_BIT];
  wire logic serial_unit_on = uart_control_two[`UIRQ_C2_UNIT_ON];
  wire logic receiver_on = uart_control_two[`UIRQ_C2_RECV_ON];
  wire logic rx_data_avail_flag = uart_status_reg[`UIRQ_ST_RX_AVAIL];

  // ----------------------------------------
  // pin and clock-off synchronisers
  // ----------------------------------------
  sync2 #(.RESET_VAL(1'b0)) u_sync_off
  (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .async_i(clock_off_i),
    .sync_o(clock_off_sync)
  );

  // idle line is high, so reset to high to avoid a false edge at release
  sync2 #(.RESET_VAL(1'b1)) u_sync_rx
  (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .async_i(rx_pin_i),
    .sync_o(rx_pin_sync)
  );

  assign rx_fall = rx_prev_reg & ~rx_pin_sync;

  // ----------------------------------------
  // register port: control two is written, status reads back flags and state
  // ----------------------------------------
  always_comb
  begin
    ctrl_next = uart_control_two;
    // no power-state term here: idle or sleep never touches the registers
    if (wr_i && addr_i == `UIRQ_OFS_CTRL2)
      ctrl_next = wdata_i;
    rdata_next = 8'h00;
    if (rd_i)
    begin
      unique case (addr_i)
        `UIRQ_OFS_CTRL2: rdata_next = uart_control_two;
        `UIRQ_OFS_STATUS:
        begin
          rdata_next[3:0] = uart_status_reg;
          rdata_next[`UIRQ_ST_ADDR_BIT] = addr_bit_reg;
          rdata_next[`UIRQ_ST_RUNNING] = (state_reg == ST_RUN);
          rdata_next[`UIRQ_ST_SETTLING] = (state_reg == ST_SETTLE);
        end
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // status flags: set by datapath events, cleared by access sequences only
  // ----------------------------------------
  always_comb
  begin
    flags_next = uart_status_reg;
    // a status read arms the receive clear; the following data read fires it
    seq_armed_next = seq_armed_reg;
    if (rd_i && addr_i == `UIRQ_OFS_STATUS)
      seq_armed_next = 1'b1;
    else if (rx_data_read_i)
      seq_armed_next = 1'b0;
    // clears first, sets after, so a same-cycle event is never lost
    if (tx_load_i)
    begin
      flags_next[`UIRQ_ST_TX_EMPTY] = 1'b0;
      flags_next[`UIRQ_ST_TX_IDLE] = 1'b0;
    end
    if (seq_armed_reg && rx_data_read_i)
    begin
      flags_next[`UIRQ_ST_RX_AVAIL] = 1'b0;
      flags_next[`UIRQ_ST_OVERRUN] = 1'b0;
    end
    if (tx_empty_set_i)
      flags_next[`UIRQ_ST_TX_EMPTY] = 1'b1;
    if (tx_idle_set_i)
      flags_next[`UIRQ_ST_TX_IDLE] = 1'b1;
    if (rx_avail_set_i)
      flags_next[`UIRQ_ST_RX_AVAIL] = 1'b1;
    if (rx_overrun_set_i)
      flags_next[`UIRQ_ST_OVERRUN] = 1'b1;
    // latch the qualifying bit of the word that raised the flag
    addr_bit_next = addr_bit_reg;
    if (rx_avail_set_i)
      addr_bit_next = qual_bit(rx_word_i, nine_bit_select);
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      uart_control_two <= `UIRQ_C2_RESET;
      uart_status_reg <= `UIRQ_FLAGS_RESET;
      addr_bit_reg <= 1'b0;
      seq_armed_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end
    else
    begin
      uart_control_two <= ctrl_next;
      uart_status_reg <= flags_next;
      addr_bit_reg <= addr_bit_next;
      seq_armed_reg <= seq_armed_next;
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------
  // source clock power state, settling and wake-up
  // ----------------------------------------
  assign wake_arm = wake_enable & serial_unit_on & receiver_on & rx_irq_enable;

  always_comb
  begin
    state_next = state_reg;
    settle_cnt_next = settle_cnt_reg;
    unique case (state_reg)
      ST_RUN:
        if (clock_off_sync)
          state_next = ST_OFF;
      ST_OFF:
        if (!clock_off_sync)
        begin
          state_next = ST_SETTLE;
          settle_cnt_next = 16'h0000;
        end
      ST_SETTLE:
        if (clock_off_sync)
          state_next = ST_OFF;
        else if (settle_cnt_reg == 16'(SETTLE_CYC - 1))
          state_next = ST_RUN;
        else
          settle_cnt_next = settle_cnt_reg + 16'h0001;
      default:
        state_next = ST_RUN;
    endcase
    // a falling edge wakes only while off and armed; interrupt only with both enables
    wake_next = (state_reg == ST_OFF) && wake_arm && rx_fall;
    wake_pend_next = wake_pend_reg;
    if (wake_next && global_irq_enable_i && serial_irq_enable_i)
      wake_pend_next = 1'b1;
    else if (wake_due)
      wake_pend_next = 1'b0;
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_reg <= ST_RUN;
      settle_cnt_reg <= 16'h0000;
      wake_pend_reg <= 1'b0;
      wake_reg <= 1'b0;
      rx_prev_reg <= 1'b1;
      run_reg <= 1'b1;
      ignore_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      settle_cnt_reg <= settle_cnt_next;
      wake_pend_reg <= wake_pend_next;
      wake_reg <= wake_next;
      rx_prev_reg <= rx_pin_sync;
      run_reg <= (state_next == ST_RUN);
      ignore_reg <= (state_next != ST_RUN);
    end
  end

  // ----------------------------------------
  // interrupt combining
  // ----------------------------------------
  // the wake interrupt only escapes once normal running is back
  assign wake_due = wake_pend_reg & (state_reg == ST_RUN);
  assign tx_src = (tx_empty_ie & uart_status_reg[`UIRQ_ST_TX_EMPTY])
    | (tx_idle_ie & uart_status_reg[`UIRQ_ST_TX_IDLE]);
  assign rx_data_src = rx_irq_enable
    & (uart_status_reg[`UIRQ_ST_OVERRUN] | (rx_data_avail_flag & ~addr_detect_enable));
  assign addr_src = addr_detect_enable & rx_data_avail_flag & addr_bit_reg;
  // the combined request is held off while the clock is off or settling
  assign irq_req = (state_reg == ST_RUN) & (tx_src | rx_data_src | addr_src | wake_due);

  always_comb
  begin
    // one low cycle per rise of the combined request
    irq_n_next = ~(irq_req & ~req_prev_reg);
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      req_prev_reg <= 1'b0;
      irq_n_reg <= 1'b1;
    end
    else
    begin
      req_prev_reg <= irq_req;
      irq_n_reg <= irq_n_next;
    end
  end

  assign rdata_o = rdata_reg;
  assign irq_n_o = irq_n_reg;
  assign wake_o = wake_reg;
  assign uart_run_o = run_reg;
  assign rx_ignore_o = ignore_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  property p_irq_pulse;
    irq_req && !req_prev_reg |=> !irq_n_o ##1 irq_n_o;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq pulse missing or long");

  property p_addr_block;
    addr_detect_enable && !addr_bit_reg && !uart_status_reg[`UIRQ_ST_OVERRUN] && !tx_src
      && !wake_due |-> !irq_req;
  endproperty
  a_addr_block: assert property (p_addr_block) else $error("unqualified word raised irq");

  property p_no_addr;
    state_reg == ST_RUN && !addr_detect_enable && rx_irq_enable && rx_data_avail_flag
      |-> irq_req;
  endproperty
  a_no_addr: assert property (p_no_addr) else $error("rx flag without irq");

  property p_qual;
    rx_avail_set_i |=> addr_bit_reg == qual_bit($past(rx_word_i), $past(nine_bit_select));
  endproperty
  a_qual: assert property (p_qual) else $error("wrong qualifying bit");

  property p_ro_flags;
    wr_i && !tx_load_i && !rx_data_read_i |=> ($past(uart_status_reg) & ~uart_status_reg) == 4'h0;
  endproperty
  a_ro_flags: assert property (p_ro_flags) else $error("flags changed by write");

  property p_wake;
    state_reg == ST_OFF && wake_arm && rx_fall |=> wake_o;
  endproperty
  a_wake: assert property (p_wake) else $error("wake pulse missing");

  property p_wake_noirq;
    !wake_pend_reg && !(global_irq_enable_i && serial_irq_enable_i) |=> !wake_pend_reg;
  endproperty
  a_wake_noirq: assert property (p_wake_noirq) else $error("wake irq without enables");

  property p_hold;
    state_reg != ST_RUN |-> !irq_req && rx_ignore_o;
  endproperty
  a_hold: assert property (p_hold) else $error("irq or data during settle");

  property p_freeze;
    state_reg == ST_OFF |=> !uart_run_o;
  endproperty
  a_freeze: assert property (p_freeze) else $error("datapath not frozen");

  property p_keep;
    $rose(clock_off_sync) && !wr_i |=> $stable(uart_control_two);
  endproperty
  a_keep: assert property (p_keep) else $error("control changed on sleep");
endmodule
`default_nettype wire

// File: test/host_irq_model.sv
// host interrupt controller model that counts vectored uart interrupts
`timescale 1ns/1ps
`default_nettype none
module host_irq_model
(
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic irq_n_i,
  input wire logic global_irq_enable_i,
  input wire logic serial_irq_enable_i,
  input wire logic stack_full_i,
  output var int vectors_o
);
  // a low pulse only vectors with both enables set and room on the return stack
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      vectors_o <= 0;
    else if (irq_n_i === 1'b0 && global_irq_enable_i && serial_irq_enable_i && !stack_full_i)
      vectors_o <= vectors_o + 1;
  end
endmodule
`default_nettype wire

// File: test/uart_irq_addr_detect_wakeup_bench.sv
// self-checking bench for the uart interrupt combiner
`timescale 1ns/1ps
`default_nettype none
`include "uart_irq_consts.svh"
module uart_irq_addr_detect_wakeup_bench;
  // ------------------------------------------------
  // signals and instances
  // ------------------------------------------------
  // short settling keeps the wake-up runs brief
  localparam int SETTLE = 4;
  logic ref_clk, arst_n, wr, rd, gie, sie, clk_off, rx_pin, irq_n, wake, run, ignore;
  logic [7:0] addr, wdata, rdata, rv;
  logic [5:0] ev;
  logic [8:0] word;
  int bad_count, checks, irq_total, irq_seen, wake_seen, vectors;

  uart_irq_addr_detect_wakeup #(.SETTLE_CYC(SETTLE)) i_dut
  (
    .ref_clk_i(ref_clk), .arst_n_i(arst_n), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .tx_empty_set_i(ev[0]),
    .tx_idle_set_i(ev[1]), .tx_load_i(ev[4]), .rx_avail_set_i(ev[2]),
    .rx_overrun_set_i(ev[3]), .rx_word_i(word), .rx_data_read_i(ev[5]),
    .global_irq_enable_i(gie), .serial_irq_enable_i(sie), .clock_off_i(clk_off),
    .rx_pin_i(rx_pin), .irq_n_o(irq_n), .wake_o(wake), .uart_run_o(run),
    .rx_ignore_o(ignore)
  );

  host_irq_model i_host
  (
    .ref_clk_i(ref_clk), .arst_n_i(arst_n), .irq_n_i(irq_n), .global_irq_enable_i(gie),
    .serial_irq_enable_i(sie), .stack_full_i(1'b0), .vectors_o(vectors)
  );

  // ------------------------------------------------
  // shared tasks
  // ------------------------------------------------
  task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(negedge ref_clk);
    rv = rdata;
  endtask

  task automatic pulse(input int b);
    @(posedge ref_clk);
    ev[b] <= 1'b1;
    @(posedge ref_clk);
    ev <= 6'h00;
  endtask

  // counts low cycles of the request line and wake pulses over a window
  task automatic watch(input int n);
    irq_seen = 0;
    wake_seen = 0;
    repeat (n)
    begin
      @(negedge ref_clk);
      if (irq_n === 1'b0)
        irq_seen++;
      if (wake === 1'b1)
        wake_seen++;
    end
    irq_total += irq_seen;
  endtask

  // tx flags clear on a load, rx flags on a status read then a data read
  task automatic clear_flags();
    pulse(4);
    bus_rd(`UIRQ_OFS_STATUS);
    pulse(5);
  endtask

  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic test_reset();
    // look between edges so no register update races the compare
    @(negedge ref_clk);
    check("irq_n", irq_n, 1'b1);
    check("run", run, 1'b1);
    check("ignore", ignore, 1'b0);
    bus_rd(`UIRQ_OFS_CTRL2);
    check("ctrl2", rv, `UIRQ_C2_RESET);
    bus_rd(`UIRQ_OFS_STATUS);
    check("status", rv, 8'h01 << `UIRQ_ST_RUNNING);
    bus_rd(8'h07);
    check("unmapped", rv, 8'h00);
  endtask

  // flag sets while masked, the interrupt follows once its enable is set
  task automatic test_sources();
    int en_bit [4] = '{`UIRQ_C2_TX_EMPTY_IE, `UIRQ_C2_TX_IDLE_IE, `UIRQ_C2_RX_IE, `UIRQ_C2_RX_IE};
    for (int i = 0; i < 4; i++)
    begin
      bus_wr(`UIRQ_OFS_CTRL2, 8'h00);
      pulse(i);
      watch(6);
      check("masked irq", irq_seen, 0);
      bus_wr(`UIRQ_OFS_STATUS, 8'h00);
      bus_rd(`UIRQ_OFS_STATUS);
      check("flag set", rv[i], 1'b1);
      bus_wr(`UIRQ_OFS_CTRL2, 8'h01 << en_bit[i]);
      watch(6);
      check("enabled irq", irq_seen, 1);
      clear_flags();
      bus_rd(`UIRQ_OFS_STATUS);
      check("flag cleared", rv[i], 1'b0);
    end
  endtask

  // receive irq with address detect off, then on with eight-bit and nine-bit qualifying bits
  task automatic test_addr_detect();
    logic [7:0] ctl [5] = '{8'h04, 8'h0c, 8'h0c, 8'h2c, 8'h2c};
    logic [8:0] wd [5] = '{9'h000, 9'h080, 9'h100, 9'h100, 9'h080};
    int exp [5] = '{1, 1, 0, 1, 0};
    for (int i = 0; i < 5; i++)
    begin
      bus_wr(`UIRQ_OFS_CTRL2, ctl[i]);
      word <= wd[i];
      pulse(2);
      watch(6);
      check("addr irq", irq_seen, exp[i]);
      clear_flags();
    end
  endtask

  // wake by a receive-pin fall while the clock is off: fully enabled, without the wake enable, then without the global enable
  task automatic test_wake();
    logic [7:0] ctl [3] = '{8'hd4, 8'hc4, 8'hd4};
    logic ge [3] = '{1'b1, 1'b1, 1'b0};
    int ew [3] = '{1, 0, 1};
    int ei [3] = '{1, 0, 0};
    for (int i = 0; i < 3; i++)
    begin
      bus_wr(`UIRQ_OFS_CTRL2, ctl[i]);
      gie <= ge[i];
      clk_off <= 1'b1;
      repeat (5) @(posedge ref_clk);
      check("run off", run, 1'b0);
      check("ignore off", ignore, 1'b1);
      rx_pin <= 1'b0;
      watch(8);
      check("wake", wake_seen, ew[i]);
      check("irq while off", irq_seen, 0);
      @(posedge ref_clk);
      clk_off <= 1'b0;
      rx_pin <= 1'b1;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      check("ignore settle", ignore, 1'b1);
      watch(20);
      check("wake irq", irq_seen, ei[i]);
      check("run back", run, 1'b1);
      check("ignore back", ignore, 1'b0);
      bus_rd(`UIRQ_OFS_CTRL2);
      check("ctrl2 kept", rv, ctl[i]);
    end
    gie <= 1'b1;
  endtask

  // ------------------------------------------------
  // clock, reset and main sequence
  // ------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // a hang counts as a failure
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    finish_test();
  end

  initial
  begin
    arst_n = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    ev = 6'h00;
    word = 9'h000;
    gie = 1'b1;
    sie = 1'b1;
    clk_off = 1'b0;
    rx_pin = 1'b1;
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    test_reset();
    test_sources();
    test_addr_detect();
    test_wake();
    repeat (2) @(posedge ref_clk);
    check("vectors", vectors, irq_total);
    finish_test();
  end
endmodule
`default_nettype wire
